// ### logic/gpcc_pkg.sv
// package: offsets, reset values and state layout of the port block
package gpcc_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;

  // port index within the block
  localparam int PORT_C = 0;
  localparam int PORT_G = 1;
  localparam int PORT_L = 2;
  localparam int PORT_F = 3;

  // ------------------------------------------------------------
  // data memory byte locations, indexed by port
  // ------------------------------------------------------------
  localparam logic [3:0][7:0] DATA_OFF = {8'h94, 8'hd0, 8'hd4, 8'hdc};
  localparam logic [3:0][7:0] CFG_OFF = {8'h95, 8'hd1, 8'hd5, 8'hdd};
  localparam logic [3:0][7:0] PINS_OFF = {8'h96, 8'hd2, 8'hd6, 8'hde};

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ------------------------------------------------------------
  // port g special bit positions
  // ------------------------------------------------------------
  localparam int G_HALT_BIT = 7;
  localparam int G_IDLE_BIT = 6;
  localparam int G_DELAY_BIT = 7;
  localparam int G_SK_PHASE_BIT = 6;
  localparam int G_OSC_PIN = 7;
  localparam int G_SI_PIN = 6;
  localparam int G_SK_PIN = 5;
  localparam int G_SO_PIN = 4;
  localparam int G_T1A_PIN = 3;
  localparam int G_T1B_PIN = 2;
  localparam int G_SUP_PIN = 1;
  localparam int G_INT_PIN = 0;
  localparam logic [7:0] G_DATA_READ_MASK = 8'h3f;

  // ------------------------------------------------------------
  // register state of the top module
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic [3:0][7:0] data;
    logic [7:0] rdata;
    logic halt;
    logic idle;
    logic g7_prev;
  } gpcc_state_s;

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] level;
  } gpcc_sync_s;

endpackage : gpcc_pkg

// ### logic/gpcc_port_pins.sv
// one 8-bit port: pin mode decode, alternate overrides, input synchroniser
module gpcc_port_pins
  import gpcc_pkg::*;
#(
  parameter int WIDTH = gpcc_pkg::PORT_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // port registers
  input wire logic [WIDTH-1:0] cfg,
  input wire logic [WIDTH-1:0] data,
  // alternate function overrides
  input wire logic [WIDTH-1:0] alt_oe,
  input wire logic [WIDTH-1:0] alt_out,
  input wire logic [WIDTH-1:0] force_hiz,
  input wire logic [WIDTH-1:0] force_pullup,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_pullup,
  output logic [WIDTH-1:0] pin_level
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (WIDTH != PORT_W)
  begin : g_width_check
    $error("port width must match the register width");
  end

  // ------------------------------------------------------------
  // synchroniser state
  // ------------------------------------------------------------
  gpcc_sync_s state;
  gpcc_sync_s next_state;

  always_comb
  begin
    next_state = state;
    next_state.meta = pin_in;
    next_state.level = state.meta;
    if (!reset_n)
    begin
      next_state = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    state <= next_state;
  end

  assign pin_level = state.level;

  // ------------------------------------------------------------
  // per-bit pin drive
  // ------------------------------------------------------------
  for (genvar b = 0; b < WIDTH; b++)
  begin : g_bit
    always_comb
    begin
      if (alt_oe[b])
      begin
        pin_oe[b] = 1'b1;
        pin_out[b] = alt_out[b];
        pin_pullup[b] = 1'b0;
      end
      else if (force_hiz[b])
      begin
        pin_oe[b] = 1'b0;
        pin_out[b] = 1'b0;
        pin_pullup[b] = 1'b0;
      end
      else if (force_pullup[b])
      begin
        pin_oe[b] = 1'b0;
        pin_out[b] = 1'b0;
        pin_pullup[b] = 1'b1;
      end
      else
      begin
        pin_oe[b] = cfg[b];
        pin_out[b] = cfg[b] & data[b];
        pin_pullup[b] = ~cfg[b] & data[b];
      end
    end
  end

endmodule : gpcc_port_pins

// ### logic/gpcc_top.sv
// port configuration and control: registers, pin modes, port g specials
//
// Function
// - config and data bits select pin mode
// - each port: config, data, pin-read locations
// - port l wakeup, timer and usart pins
// - g6 always a high-impedance input
// - supervisor option owns g1, bit ignored
// - crystal option drives g7 with clock
// - g7 rising edge releases halt mode, only without the crystal option
// - port g data bits 6,7 read zero
// - writing g data bit 7 enters halt
// - writing g data bit 6 enters idle
// - g config bit 6 flips shift clock phase
// - g config bit 7 enables halt-exit delay, only without the crystal option
// - port f pins serve both comparators
// - port g alternate serial, timer, interrupt pins
module gpcc_top
  import gpcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // data memory access from the core
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // mask options
  input wire logic supervisor_option,
  input wire logic crystal_option,
  // port pins, indexed c, g, l, f
  input wire logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_in,
  output logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_out,
  output logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_oe,
  output logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_pullup,
  // clock and supervisory sources
  input wire logic oscillator_clock_output,
  input wire logic supervisor_output_pin,
  // low power control
  input wire logic wake_request,
  output logic halt_mode,
  output logic idle_mode,
  output logic halt_exit_delay_enable,
  output logic sk_alt_phase,
  // serial shift interface
  input wire logic serial_shift_clock_oe,
  input wire logic serial_shift_clock_out,
  input wire logic serial_data_out_en,
  input wire logic serial_data_out,
  output logic serial_data_in,
  output logic serial_shift_clock,
  // timer 1 and interrupt
  input wire logic timer1_out_en,
  input wire logic timer1_out,
  output logic timer1_io_pin,
  output logic timer1_capture_pin,
  output logic external_interrupt_pin,
  // port l alternates
  input wire logic usart_tx_en,
  input wire logic usart_tx,
  input wire logic usart_clk_oe,
  input wire logic usart_clk_out,
  output logic [7:0] multi_input_wakeup,
  output logic timer2_input_a,
  output logic timer2_input_b,
  output logic timer3_input_a,
  output logic timer3_input_b,
  output logic serial_receive_pin,
  output logic serial_clock_pin,
  // comparators
  input wire logic comp1_en,
  input wire logic comp2_en,
  input wire logic first_comparator_output,
  input wire logic second_comparator_output
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  gpcc_state_s state;
  gpcc_state_s next_state;
  logic [NUM_PORTS-1:0][7:0] level;
  logic [NUM_PORTS-1:0][7:0] alt_oe;
  logic [NUM_PORTS-1:0][7:0] alt_out;
  logic [NUM_PORTS-1:0][7:0] force_hiz;
  logic [NUM_PORTS-1:0][7:0] force_pullup;
  logic g7_rise;
  logic [NUM_PORTS-1:0] cfg_hit;
  logic [NUM_PORTS-1:0] data_hit;
  logic [NUM_PORTS-1:0] pins_hit;
  logic halt_set;
  logic idle_set;
  logic halt_clear;
  logic idle_clear;
  logic [7:0] read_value;

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if ($bits(DATA_OFF) != NUM_PORTS * PORT_W)
  begin : g_ports_check
    $error("offset tables must hold one byte per port");
  end

  // ------------------------------------------------------------
  // alternate function overrides
  // ------------------------------------------------------------
  always_comb
  begin
    alt_oe = '0;
    alt_out = '0;
    force_hiz = '0;
    force_pullup = '0;
    // port g
    force_hiz[PORT_G][G_SI_PIN] = 1'b1;
    alt_oe[PORT_G][G_OSC_PIN] = crystal_option;
    alt_out[PORT_G][G_OSC_PIN] = oscillator_clock_output;
    force_hiz[PORT_G][G_OSC_PIN] = ~crystal_option;
    alt_oe[PORT_G][G_SUP_PIN] =
      supervisor_option & ~supervisor_output_pin;
    force_pullup[PORT_G][G_SUP_PIN] = supervisor_option;
    alt_oe[PORT_G][G_SK_PIN] = serial_shift_clock_oe;
    alt_out[PORT_G][G_SK_PIN] = serial_shift_clock_out;
    alt_oe[PORT_G][G_SO_PIN] = serial_data_out_en;
    alt_out[PORT_G][G_SO_PIN] = serial_data_out;
    alt_oe[PORT_G][G_T1A_PIN] = timer1_out_en;
    alt_out[PORT_G][G_T1A_PIN] = timer1_out;
    // port l
    alt_oe[PORT_L][2] = usart_tx_en;
    alt_out[PORT_L][2] = usart_tx;
    alt_oe[PORT_L][1] = usart_clk_oe;
    alt_out[PORT_L][1] = usart_clk_out;
    // port f
    force_hiz[PORT_F][1] = comp1_en;
    force_hiz[PORT_F][2] = comp1_en;
    alt_oe[PORT_F][3] = comp1_en;
    alt_out[PORT_F][3] = first_comparator_output;
    force_hiz[PORT_F][4] = comp2_en;
    force_hiz[PORT_F][5] = comp2_en;
    alt_oe[PORT_F][6] = comp2_en;
    alt_out[PORT_F][6] = second_comparator_output;
  end

  // ------------------------------------------------------------
  // per-port pin logic
  // ------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    gpcc_port_pins #(
      .WIDTH(PORT_W)
    ) u_pins (
      .mclk(mclk),
      .reset_n(reset_n),
      .cfg(state.cfg[p]),
      .data(state.data[p]),
      .alt_oe(alt_oe[p]),
      .alt_out(alt_out[p]),
      .force_hiz(force_hiz[p]),
      .force_pullup(force_pullup[p]),
      .pin_in(pin_in[p]),
      .pin_out(pin_out[p]),
      .pin_oe(pin_oe[p]),
      .pin_pullup(pin_pullup[p]),
      .pin_level(level[p])
    );
  end

  // ------------------------------------------------------------
  // wake edge on g7, only without the crystal
  // ------------------------------------------------------------
  assign g7_rise = ~crystal_option & level[PORT_G][G_OSC_PIN]
                   & ~state.g7_prev;

  // ------------------------------------------------------------
  // byte location decode, one set of compares per port
  // ------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_decode
    assign cfg_hit[p] = (cpu_addr == CFG_OFF[p]);
    assign data_hit[p] = (cpu_addr == DATA_OFF[p]);
    assign pins_hit[p] = (cpu_addr == PINS_OFF[p]);
  end

  // ------------------------------------------------------------
  // low power set and clear events
  // ------------------------------------------------------------
  assign halt_set = cpu_wr & data_hit[PORT_G]
                    & cpu_wdata[G_HALT_BIT];
  assign idle_set = cpu_wr & data_hit[PORT_G]
                    & cpu_wdata[G_IDLE_BIT];
  assign halt_clear = g7_rise | wake_request;
  assign idle_clear = wake_request;

  // ------------------------------------------------------------
  // read data select; unmapped locations read zero
  // ------------------------------------------------------------
  always_comb
  begin
    read_value = 8'h00;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (cfg_hit[i])
      begin
        read_value = state.cfg[i];
      end
      if (data_hit[i])
      begin
        read_value = state.data[i];
        if (i == PORT_G)
        begin
          read_value = state.data[i] & G_DATA_READ_MASK;
        end
      end
      if (pins_hit[i])
      begin
        read_value = level[i];
      end
    end
  end

  // ------------------------------------------------------------
  // register file and low power control
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.g7_prev = level[PORT_G][G_OSC_PIN];
    // a set write wins over a wake in the same cycle
    if (halt_set)
    begin
      next_state.halt = 1'b1;
    end
    else if (halt_clear)
    begin
      next_state.halt = 1'b0;
    end
    if (idle_set)
    begin
      next_state.idle = 1'b1;
    end
    else if (idle_clear)
    begin
      next_state.idle = 1'b0;
    end
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (cpu_wr && cfg_hit[i])
      begin
        next_state.cfg[i] = cpu_wdata;
      end
      if (cpu_wr && data_hit[i])
      begin
        next_state.data[i] = cpu_wdata;
        if (i == PORT_G)
        begin
          next_state.data[i] = cpu_wdata & G_DATA_READ_MASK;
        end
      end
    end
    // reads answer on the next edge
    if (cpu_rd)
    begin
      next_state.rdata = read_value;
    end
    if (!reset_n)
    begin
      next_state.cfg = {NUM_PORTS{CFG_RESET}};
      next_state.data = {NUM_PORTS{DATA_RESET}};
      next_state.rdata = RDATA_RESET;
      next_state.halt = 1'b0;
      next_state.idle = 1'b0;
      next_state.g7_prev = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    state <= next_state;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign cpu_rdata = state.rdata;
  assign halt_mode = state.halt;
  assign idle_mode = state.idle;
  assign halt_exit_delay_enable =
    state.cfg[PORT_G][G_DELAY_BIT] & ~crystal_option;
  assign sk_alt_phase = state.cfg[PORT_G][G_SK_PHASE_BIT];

  assign serial_data_in = level[PORT_G][G_SI_PIN];
  assign serial_shift_clock = level[PORT_G][G_SK_PIN];
  assign timer1_io_pin = level[PORT_G][G_T1A_PIN];
  assign timer1_capture_pin = level[PORT_G][G_T1B_PIN];
  assign external_interrupt_pin = level[PORT_G][G_INT_PIN];

  assign multi_input_wakeup = level[PORT_L];
  assign timer2_input_a = level[PORT_L][4];
  assign timer2_input_b = level[PORT_L][5];
  assign timer3_input_a = level[PORT_L][6];
  assign timer3_input_b = level[PORT_L][7];
  assign serial_receive_pin = level[PORT_L][3];
  assign serial_clock_pin = level[PORT_L][1];

endmodule : gpcc_top

// ### tb/gpcc_top_asserts.sv
// checker: pin relations and timing of the port block
module gpcc_top_asserts
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register access
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  // options and pins
  input wire logic supervisor_option,
  input wire logic crystal_option,
  input wire logic oscillator_clock_output,
  input wire logic supervisor_output_pin,
  input wire logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_in,
  input wire logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_out,
  input wire logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_oe,
  input wire logic [gpcc_pkg::NUM_PORTS-1:0][7:0] pin_pullup,
  // low power
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic halt_exit_delay_enable,
  input wire logic sk_alt_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpcc_pkg::*;
  logic g_wr;
  logic g_rd;
  assign g_wr = cpu_wr && cpu_addr == DATA_OFF[PORT_G];
  assign g_rd = cpu_rd && cpu_addr == DATA_OFF[PORT_G];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ----
  // assertions
  // ----
  a_g6_never_driven: assert property (!pin_oe[1][6])
    else $error("g6 driven");
  a_g1_supervisor: assert property (supervisor_option |->
    (supervisor_output_pin ? pin_pullup[1][1] && !pin_oe[1][1]
    : pin_oe[1][1] && !pin_out[1][1])) else $error("g1 setup wrong");
  a_g7_clock_out: assert property (crystal_option |->
    pin_oe[1][7] && pin_out[1][7] == oscillator_clock_output)
    else $error("g7 clock not driven");
  a_g7_input_only: assert property (!crystal_option |->
    !pin_oe[1][7]) else $error("g7 driven");
  a_g7_wakes_halt: assert property (halt_mode && !crystal_option
    && $rose(pin_in[1][7]) && !g_wr |-> ##[1:4] !halt_mode)
    else $error("g7 rise kept halt");
  a_halt_on_write: assert property (g_wr && cpu_wdata[7] |=>
    halt_mode) else $error("halt not entered");
  a_idle_on_write: assert property (g_wr && cpu_wdata[6] |=>
    idle_mode) else $error("idle not entered");
  a_g_high_zero: assert property (g_rd |=>
    cpu_rdata[7:6] == 2'h0) else $error("g data high bits set");
  a_phase_follows: assert property (cpu_wr &&
    cpu_addr == CFG_OFF[PORT_G] |=> sk_alt_phase == $past(cpu_wdata[6]))
    else $error("phase bit wrong");
  a_delay_gated: assert property (crystal_option |->
    !halt_exit_delay_enable) else $error("delay under crystal");
  a_rdata_holds: assert property (!cpu_rd |=>
    $stable(cpu_rdata)) else $error("read data moved");
  c_halt_exit: cover property (halt_mode ##1 !halt_mode);
  c_idle_set: cover property (g_wr && cpu_wdata[6]);
  c_sup_low: cover property (supervisor_option && !supervisor_output_pin);
endmodule : gpcc_top_asserts

// ### tb/gpio_port_config_control_test.sv
// testbench: register access and pin behaviour of the port block
module gpio_port_config_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpcc_pkg::*;
  logic mclk = 0, reset_n = 0, cpu_wr = 0, cpu_rd = 0;
  logic [7:0] cpu_addr = '0, cpu_wdata = '0, cpu_rdata, v;
  logic supervisor_option = 0, crystal_option = 0, wake_request = 0;
  logic oscillator_clock_output = 0, supervisor_output_pin = 1;
  logic [3:0][7:0] pin_in = '0, pin_out, pin_oe, pin_pullup;
  logic halt_mode, idle_mode, halt_exit_delay_enable, sk_alt_phase;
  logic serial_shift_clock_oe = 0, serial_shift_clock_out = 0;
  logic serial_data_out_en = 0, serial_data_out = 0;
  logic timer1_out_en = 0, timer1_out = 0, usart_tx_en = 0, usart_tx = 0;
  logic usart_clk_oe = 0, usart_clk_out = 0, comp1_en = 0, comp2_en = 0;
  logic first_comparator_output = 0, second_comparator_output = 0;
  logic serial_data_in, serial_shift_clock, timer1_io_pin;
  logic timer1_capture_pin, external_interrupt_pin, serial_receive_pin;
  logic timer2_input_a, timer2_input_b, timer3_input_a, timer3_input_b;
  logic serial_clock_pin;
  logic [7:0] multi_input_wakeup;
  int fails = 0, num_checks = 0, cyc = 0;
  gpcc_top uut (.mclk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata, .supervisor_option, .crystal_option, .pin_in, .pin_out,
    .pin_oe, .pin_pullup, .oscillator_clock_output, .supervisor_output_pin,
    .wake_request, .halt_mode, .idle_mode, .halt_exit_delay_enable,
    .sk_alt_phase, .serial_shift_clock_oe, .serial_shift_clock_out,
    .serial_data_out_en, .serial_data_out, .serial_data_in,
    .serial_shift_clock, .timer1_out_en, .timer1_out, .timer1_io_pin,
    .timer1_capture_pin, .external_interrupt_pin, .usart_tx_en, .usart_tx,
    .usart_clk_oe, .usart_clk_out, .multi_input_wakeup, .timer2_input_a,
    .timer2_input_b, .timer3_input_a, .timer3_input_b, .serial_receive_pin,
    .serial_clock_pin, .comp1_en, .comp2_en, .first_comparator_output,
    .second_comparator_output);
  always #2.5 mclk = ~mclk;
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    cpu_wr <= 1'h1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    cpu_rd <= 1'h1;
    cpu_addr <= a;
    @(posedge mclk);
    cpu_rd <= 1'h0;
    #1;
    v = cpu_rdata;
  endtask : rd
  task automatic close_out();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      close_out();
    end
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    for (int p = 0; p < 4; p++)
    begin
      rd(CFG_OFF[p]);
      chk("cfg", 8'h00, v);
      rd(DATA_OFF[p]);
      chk("data", 8'h00, v);
      chk("oe", 8'h00, pin_oe[p]);
      if (p != PORT_G)
      begin
        wr(CFG_OFF[p], 8'h0f);
        wr(DATA_OFF[p], 8'h55);
        rd(DATA_OFF[p]);
        chk("data", 8'h55, v);
        chk("oe", 8'h0f, pin_oe[p]);
        chk("out", 8'h05, pin_out[p] & 8'h0f);
        chk("pu", 8'h50, pin_pullup[p]);
      end
    end
    wr(8'h00, 8'hff);
    rd(8'h00);
    chk("unmapped", 8'h00, v);
    @(posedge mclk);
    pin_in[2] <= 8'h58;
    pin_in[1] <= 8'h4d;
    rd(PINS_OFF[PORT_L]);
    chk("pins early", 8'h00, v);
    rd(PINS_OFF[PORT_L]);
    chk("pins l", 8'h58, v);
    rd(PINS_OFF[PORT_G]);
    chk("pins g", 8'h4d, v);
    chk("wake", 8'h58, multi_input_wakeup);
    chk("l alt", 8'h16, {timer3_input_b, timer3_input_a, timer2_input_b,
      timer2_input_a, serial_receive_pin, serial_clock_pin});
    chk("g alt", 8'h17, {serial_data_in, serial_shift_clock, timer1_io_pin,
      timer1_capture_pin, external_interrupt_pin});
    wr(DATA_OFF[PORT_G], 8'hff);
    rd(DATA_OFF[PORT_G]);
    chk("g data", 8'h3f, v);
    chk("modes", 8'h03, {halt_mode, idle_mode});
    @(posedge mclk) wake_request <= 1'h1;
    @(posedge mclk) wake_request <= 1'h0;
    wr(DATA_OFF[PORT_G], 8'h40);
    chk("idle", 8'h01, {halt_mode, idle_mode});
    @(posedge mclk) wake_request <= 1'h1;
    @(posedge mclk) wake_request <= 1'h0;
    wr(DATA_OFF[PORT_G], 8'h80);
    chk("halt", 8'h02, {halt_mode, idle_mode});
    @(posedge mclk);
    pin_in[1][7] <= 1'h1;
    step(6);
    chk("g7 wake", 8'h00, halt_mode);
    @(posedge mclk);
    pin_in[1][7] <= 1'h0;
    crystal_option <= 1'h1;
    oscillator_clock_output <= 1'h1;
    wr(DATA_OFF[PORT_G], 8'h80);
    @(posedge mclk);
    pin_in[1][7] <= 1'h1;
    step(6);
    chk("g7 ignored", 8'h01, halt_mode);
    chk("osc", 8'h80, pin_oe[1] & pin_out[1] & 8'h80);
    wr(CFG_OFF[PORT_G], 8'hff);
    chk("phase dly", 8'h02,
      {sk_alt_phase, halt_exit_delay_enable});
    @(posedge mclk);
    crystal_option <= 1'h0;
    wake_request <= 1'h1;
    @(posedge mclk) wake_request <= 1'h0;
    step(1);
    chk("dly rc", 8'h01, halt_exit_delay_enable);
    wr(DATA_OFF[PORT_G], 8'h3f);
    chk("g oe", 8'h3f, pin_oe[1]);
    @(posedge mclk);
    supervisor_option <= 1'h1;
    step(1);
    chk("g1 pu", 8'h02, pin_pullup[1] & ~pin_oe[1] & 8'h02);
    @(posedge mclk);
    supervisor_output_pin <= 1'h0;
    step(1);
    chk("g1 low", 8'h02, pin_oe[1] & ~pin_out[1] & 8'h02);
    @(posedge mclk);
    {serial_shift_clock_oe, serial_data_out_en, timer1_out_en} <= 3'h7;
    {usart_tx_en, usart_tx, usart_clk_oe, comp1_en, comp2_en} <= 5'h1f;
    first_comparator_output <= 1'h1;
    wr(CFG_OFF[PORT_L], 8'h00);
    chk("g alt out", 8'h00, pin_out[1] & 8'h38);
    chk("l alt oe", 8'h06, pin_oe[2]);
    chk("l alt out", 8'h04, pin_out[2] & 8'h06);
    chk("f oe", 8'h49, pin_oe[3]);
    chk("f pu", 8'h00, pin_pullup[3]);
    chk("f out", 8'h08, pin_out[3] & 8'h48);
    close_out();
  end
endmodule : gpio_port_config_control_test
bind gpcc_top gpcc_top_asserts chk_i (.mclk, .reset_n, .cpu_addr, .cpu_wr,
  .cpu_rd, .cpu_wdata, .cpu_rdata, .supervisor_option, .crystal_option,
  .oscillator_clock_output, .supervisor_output_pin, .pin_in, .pin_out,
  .pin_oe, .pin_pullup, .halt_mode, .idle_mode, .halt_exit_delay_enable,
  .sk_alt_phase);
